// File: hw/gcr_general_control.sv
// general control register at offset zero of the clock generator
//
// Overview of operation
// (RULE1) bit 15 gives the slave address low bit saved with a page commit
// (RULE2) a page load puts the saved address low bit back into bit 15
// (RULE3) bit 14 selects pin 8 input: zero reset, one synchronization
// (RULE4) bits 13, 12, 11 set pin four, one, zero direction; one output
// (RULE5) in zero-delay mode bit 10 picks internal or external feedback
// (RULE6) without zero-delay mode calibration always uses internal clock
// (RULE7) bit 8 turns zero-delay mode on
// (RULE8) bit 6 holds the lock detector in reset while set
// (RULE9) writing one to bit 5 gives one divider sync pulse, self clearing
// (RULE10) writing one to bit 4 starts a recalibration, self clearing
// (RULE11) later recalibration starts from held capacitor and cross codes
// (RULE12) the whole register resets to zero
// (RULE13) bit 3 picks whether the reset pin also clears the registers
// (RULE14) writing one to bit 2 pulses a core reset and restarts config
// (RULE15) bit 1 powers down the analog part; bit 0 selects pin mode
// (RULE16) pulse bits read back zero once their pulse has gone out
module gcr_general_control
  import gcr_pkg::*;
#(
  parameter int unsigned CODE_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // external reset pin, already qualified by the pin function
  input wire logic pin_reset_b_i,
  // register access
  input wire gcr_req_t req_i,
  output logic [GCR_DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // nonvolatile page interface
  input wire gcr_nv_t nv_load_i,
  output logic nv_addr_lsb_o,
  // calibration engine
  input wire logic cal_done_i,
  input wire logic [CODE_W-1:0] cap_code_i,
  input wire logic [CODE_W-1:0] cross_code_i,
  output logic cal_start_o,
  output logic cal_use_held_o,
  output logic [CODE_W-1:0] cal_seed_cap_o,
  output logic [CODE_W-1:0] cal_seed_cross_o,
  // core controls
  output gcr_ctrl_t ctrl_o,
  output logic div_sync_o,
  output logic core_reset_o,
  output logic sm_reset_o
);

  initial begin
    if (GCR_DATA_W != 16) begin
      $error("gcr_general_control: register must be 16 bits");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic [GCR_DATA_W-1:0] reg_q;
  logic [GCR_DATA_W-1:0] reg_d;
  logic [GCR_DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic pin_rst_q;
  gcr_ctrl_t ctrl_q;
  gcr_ctrl_t ctrl_d;
  logic nv_lsb_q;
  logic sm_rst_q;

  wire logic hit = gcr_hit(req_i.addr);
  wire logic wr_hit = req_i.wr & hit;
  wire logic rd_hit = req_i.rd & hit;
  wire logic fire_sync = wr_hit & req_i.wdata[GCR_SYNC_POS]; // RULE9
  wire logic fire_recal = wr_hit & req_i.wdata[GCR_RECAL_POS]; // RULE10
  wire logic fire_swrst = wr_hit & req_i.wdata[GCR_SOFT_RESET_POS]; // RULE14
  wire logic pin_reset = ~pin_reset_b_i;
  // hard reset from the pin clears registers unless soft mode is chosen
  wire logic pin_clears_regs =
    pin_reset & ~reg_q[GCR_PIN_RESET_SOFT_POS]; // RULE13

  logic sync_pulse;
  logic swrst_pulse;
  logic cal_start;

  ////////////////////////////////////////////////////////////////////////
  // register next value

  always_comb begin
    reg_d = reg_q;
    if (pin_clears_regs) begin
      reg_d = GCR_GENERAL_CONTROL_RST; // RULE13
    end else begin
      if (wr_hit) begin
        // pulse bits never store, so they read zero afterwards
        reg_d = req_i.wdata & GCR_STORE_MASK; // RULE9 RULE10 RULE14 RULE16
      end
      if (nv_load_i.load) begin
        reg_d[GCR_SLAVE_ADDR_LOW_BIT_POS] = nv_load_i.addr_lsb; // RULE2
      end
    end
  end

  // control decode: feedback select only counts in zero-delay mode
  always_comb begin
    ctrl_d.pin8_input_function = reg_q[GCR_PIN8_INPUT_FUNCTION_POS]; // RULE3
    ctrl_d.pin_four_direction = reg_q[GCR_PIN_FOUR_DIRECTION_POS]; // RULE4
    ctrl_d.pin_one_direction = reg_q[GCR_PIN_ONE_DIRECTION_POS]; // RULE4
    ctrl_d.pin_zero_direction = reg_q[GCR_PIN_ZERO_DIRECTION_POS]; // RULE4
    ctrl_d.zero_delay_en = reg_q[GCR_ZERO_DELAY_EN_POS]; // RULE7
    ctrl_d.cal_clk_external = reg_q[GCR_ZERO_DELAY_EN_POS] &
      reg_q[GCR_CAL_CLK_SEL_POS]; // RULE5 RULE6
    ctrl_d.lockdet_rst = reg_q[GCR_LOCKDET_RST_POS]; // RULE8
    ctrl_d.pin_reset_soft = reg_q[GCR_PIN_RESET_SOFT_POS]; // RULE13
    ctrl_d.power_down = reg_q[GCR_POWER_DOWN_POS]; // RULE15
    ctrl_d.pin_mode = reg_q[GCR_PIN_MODE_POS]; // RULE15
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse generators

  gcr_pulse_gen u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .fire_i(fire_sync),
    .pulse_o(sync_pulse),
    .pending_o()
  );

  gcr_pulse_gen u_swrst (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .fire_i(fire_swrst),
    .pulse_o(swrst_pulse),
    .pending_o()
  );

  gcr_recal_ctl #(
    .CODE_W(CODE_W)
  ) u_recal (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .recal_i(fire_recal),
    .restart_i(swrst_pulse | pin_rst_q),
    .cal_done_i(cal_done_i),
    .cap_code_i(cap_code_i),
    .cross_code_i(cross_code_i),
    .cal_start_o(cal_start),
    .use_held_o(cal_use_held_o),
    .seed_cap_o(cal_seed_cap_o),
    .seed_cross_o(cal_seed_cross_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_q <= GCR_GENERAL_CONTROL_RST; // RULE12
      ctrl_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      nv_lsb_q <= 1'b0;
      pin_rst_q <= 1'b0;
      sm_rst_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      ctrl_q <= ctrl_d;
      rvalid_q <= rd_hit;
      rdata_q <= rd_hit ? reg_q : '0; // RULE16
      nv_lsb_q <= reg_q[GCR_SLAVE_ADDR_LOW_BIT_POS]; // RULE1
      pin_rst_q <= pin_reset;
      // state machines reset from the pin in either mode, or soft reset
      sm_rst_q <= pin_reset | fire_swrst; // RULE13 RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign nv_addr_lsb_o = nv_lsb_q; // RULE1
  assign ctrl_o = ctrl_q;
  assign div_sync_o = sync_pulse; // RULE9
  assign core_reset_o = swrst_pulse; // RULE14
  assign sm_reset_o = sm_rst_q;
  assign cal_start_o = cal_start; // RULE10

endmodule : gcr_general_control

// File: hw/gcr_pkg.sv
// package for the general control register block: offsets, fields, types
package gcr_pkg;

  localparam int unsigned GCR_DATA_W = 16;
  localparam int unsigned GCR_ADDR_W = 8;

  // register offset
  localparam logic [7:0] GCR_GENERAL_CONTROL_OFS = 8'h00;

  // field positions
  localparam int unsigned GCR_SLAVE_ADDR_LOW_BIT_POS = 15;
  localparam int unsigned GCR_PIN8_INPUT_FUNCTION_POS = 14;
  localparam int unsigned GCR_PIN_FOUR_DIRECTION_POS = 13;
  localparam int unsigned GCR_PIN_ONE_DIRECTION_POS = 12;
  localparam int unsigned GCR_PIN_ZERO_DIRECTION_POS = 11;
  localparam int unsigned GCR_CAL_CLK_SEL_POS = 10;
  localparam int unsigned GCR_ZERO_DELAY_EN_POS = 8;
  localparam int unsigned GCR_LOCKDET_RST_POS = 6;
  localparam int unsigned GCR_SYNC_POS = 5;
  localparam int unsigned GCR_RECAL_POS = 4;
  localparam int unsigned GCR_PIN_RESET_SOFT_POS = 3;
  localparam int unsigned GCR_SOFT_RESET_POS = 2;
  localparam int unsigned GCR_POWER_DOWN_POS = 1;
  localparam int unsigned GCR_PIN_MODE_POS = 0;

  // reset value of the whole register
  localparam logic [15:0] GCR_GENERAL_CONTROL_RST = 16'h0000;

  // bits that store; the self-clearing ones never hold a one
  localparam logic [15:0] GCR_STORE_MASK = 16'hffcb;
  localparam logic [15:0] GCR_PULSE_MASK = 16'h0034;

  // length of the pulses handed to the divider, calibrator and core
  localparam int unsigned GCR_PULSE_CYCLES = 1;

  // register access request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } gcr_req_t;

  // nonvolatile page handshake
  typedef struct packed {
    logic load;
    logic addr_lsb;
  } gcr_nv_t;

  // decoded controls toward the analog and digital core
  typedef struct packed {
    logic pin8_input_function;
    logic pin_four_direction;
    logic pin_one_direction;
    logic pin_zero_direction;
    logic cal_clk_external;
    logic zero_delay_en;
    logic lockdet_rst;
    logic pin_reset_soft;
    logic power_down;
    logic pin_mode;
  } gcr_ctrl_t;

  typedef enum logic [1:0] {
    GCR_CAL_IDLE = 2'b00,
    GCR_CAL_START = 2'b01,
    GCR_CAL_WAIT = 2'b10
  } gcr_cal_state_t;

  function automatic logic gcr_hit(input logic [7:0] addr);
    return addr == GCR_GENERAL_CONTROL_OFS;
  endfunction : gcr_hit

endpackage : gcr_pkg

// File: hw/gcr_pulse_gen.sv
// self-clearing command bit: one pulse per written one
module gcr_pulse_gen
  import gcr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // request
  input wire logic fire_i,
  // pulse out
  output logic pulse_o,
  output logic pending_o
);

  logic pulse_q;
  logic pulse_d;

  // a write of zero never reaches fire_i, so it has no effect
  assign pulse_d = fire_i;
  assign pulse_o = pulse_q;
  assign pending_o = pulse_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

endmodule : gcr_pulse_gen

// File: hw/gcr_recal_ctl.sv
// recalibration starter: seeds from the held codes after first calibration
module gcr_recal_ctl
  import gcr_pkg::*;
#(
  parameter int unsigned CODE_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // requests
  input wire logic recal_i,
  input wire logic restart_i,
  input wire logic cal_done_i,
  input wire logic [CODE_W-1:0] cap_code_i,
  input wire logic [CODE_W-1:0] cross_code_i,
  // calibration engine start
  output logic cal_start_o,
  output logic use_held_o,
  output logic [CODE_W-1:0] seed_cap_o,
  output logic [CODE_W-1:0] seed_cross_o
);

  initial begin
    if (CODE_W < 1 || CODE_W > 16) begin
      $error("gcr_recal_ctl: CODE_W out of range");
    end
  end

  logic first_done_q;
  logic start_q;
  logic held_q;
  logic [CODE_W-1:0] cap_q;
  logic [CODE_W-1:0] cross_q;
  wire logic go = recal_i | restart_i;
  // a soft reset restarts from defaults; a later recal keeps the codes
  wire logic from_held = recal_i & first_done_q & ~restart_i;

  assign cal_start_o = start_q;
  assign use_held_o = held_q;
  assign seed_cap_o = cap_q;
  assign seed_cross_o = cross_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_done_q <= 1'b0;
      start_q <= 1'b0;
      held_q <= 1'b0;
      cap_q <= '0;
      cross_q <= '0;
    end else begin
      start_q <= go;
      if (restart_i) begin
        first_done_q <= 1'b0;
      end else if (cal_done_i) begin
        first_done_q <= 1'b1;
      end
      if (go) begin
        held_q <= from_held; // RULE11
        cap_q <= from_held ? cap_code_i : '0; // RULE11
        cross_q <= from_held ? cross_code_i : '0; // RULE11
      end
    end
  end

endmodule : gcr_recal_ctl

// File: verification/gcr_general_control_sva.sv
// port assertions for the general control register
module gcr_general_control_sva
  import gcr_pkg::*;
#(
  parameter int unsigned CODE_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_reset_b_i,
  // register access
  input wire gcr_req_t req_i,
  input wire logic [GCR_DATA_W-1:0] rdata_o,
  input wire logic rvalid_o,
  // page and calibration
  input wire gcr_nv_t nv_load_i,
  input wire logic nv_addr_lsb_o,
  input wire logic cal_done_i,
  input wire logic [CODE_W-1:0] cap_code_i,
  input wire logic [CODE_W-1:0] cross_code_i,
  input wire logic cal_start_o,
  input wire logic cal_use_held_o,
  input wire logic [CODE_W-1:0] cal_seed_cap_o,
  input wire logic [CODE_W-1:0] cal_seed_cross_o,
  // core controls
  input wire gcr_ctrl_t ctrl_o,
  input wire logic div_sync_o,
  input wire logic core_reset_o,
  input wire logic sm_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire wr_hit = req_i.wr && req_i.addr == 8'h00 && pin_reset_b_i;
  wire rd_hit = req_i.rd && req_i.addr == 8'h00;
  wire quiet = !req_i.wr && !nv_load_i.load && pin_reset_b_i;
  ////////////////////////////////////////////////////////////////////////
  a_reset_zero:
  assert property ($rose(rst_b_i) |-> ctrl_o == '0 && !rvalid_o)
    else $error("outputs not zero after reset");
  a_read_answer:
  assert property (rd_hit |=> rvalid_o && (rdata_o & 16'h0034) == 16'h0000)
    else $error("read answer missing or pulse bit set");
  a_no_stray_read:
  assert property (rvalid_o |-> $past(rd_hit))
    else $error("read answer without request");
  a_sync_pulse:
  assert property (wr_hit && req_i.wdata[5] |=> div_sync_o ##1 !div_sync_o)
    else $error("sync pulse wrong");
  a_sync_cause:
  assert property (div_sync_o |->
    $past(req_i.wr && req_i.addr == 8'h00 && req_i.wdata[5]))
    else $error("sync pulse without write of one");
  a_recal_start:
  assert property (wr_hit && req_i.wdata[4] |=> cal_start_o)
    else $error("recalibration not started");
  a_soft_reset:
  assert property (wr_hit && req_i.wdata[2] |=> core_reset_o && sm_reset_o)
    else $error("soft reset pulse missing");
  a_feedback_gate:
  assert property (ctrl_o.cal_clk_external |-> ctrl_o.zero_delay_en)
    else $error("external feedback outside zero delay mode");
  a_commit_lsb:
  assert property (wr_hit && !nv_load_i.load ##1 quiet |=>
    nv_addr_lsb_o == $past(req_i.wdata[15], 2))
    else $error("address low bit not taken from write");
  a_load_lsb:
  assert property (nv_load_i.load && pin_reset_b_i ##1 quiet |=>
    nv_addr_lsb_o == $past(nv_load_i.addr_lsb, 2))
    else $error("address low bit not taken from page");
  a_pin_clear:
  assert property ((!pin_reset_b_i && !ctrl_o.pin_reset_soft)[*3] |->
    ctrl_o == '0)
    else $error("hard pin reset kept controls");
  a_pin_sm_reset:
  assert property (!pin_reset_b_i |-> ##[1:2] sm_reset_o)
    else $error("state machine reset missing");
endmodule : gcr_general_control_sva

bind gcr_general_control gcr_general_control_sva #(.CODE_W(CODE_W)) sva_u (.*);

// File: verification/gcr_host_model.sv
// host model issuing one register request at a time
module gcr_host_model
  import gcr_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // read answer
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  // request
  output gcr_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // idle fields show inverted values so nothing relies on stale ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    @(posedge ref_clk_i);
    v = rvalid_i;
    d = rdata_i;
  endtask : rd
endmodule : gcr_host_model

// File: verification/tb_generic_control_register.sv
// self-checking bench for the general control register
module tb_generic_control_register
  import gcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, rst_b_i, pin_reset_b_i, cal_done_i, v;
  gcr_req_t req_i;
  gcr_nv_t nv_load_i;
  gcr_ctrl_t ctrl_o;
  logic [7:0] cap_code_i, cross_code_i, cal_seed_cap_o, cal_seed_cross_o;
  logic [15:0] rdata_o, w, e, d, p;
  logic [3:0] pulses;
  logic rvalid_o, nv_addr_lsb_o, cal_start_o, cal_use_held_o;
  logic div_sync_o, core_reset_o, sm_reset_o;
  int fails, cmp_count, cyc, seed, i;
  gcr_general_control #(.CODE_W(8)) dut_u (.ref_clk_i, .rst_b_i,
    .pin_reset_b_i, .req_i, .rdata_o, .rvalid_o, .nv_load_i, .nv_addr_lsb_o,
    .cal_done_i, .cap_code_i, .cross_code_i, .cal_start_o,
    .cal_use_held_o, .cal_seed_cap_o, .cal_seed_cross_o, .ctrl_o,
    .div_sync_o, .core_reset_o, .sm_reset_o);
  gcr_host_model host_u (.ref_clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .req_o(req_i));
  assign pulses = {div_sync_o, cal_start_o, core_reset_o, sm_reset_o};
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_ctrl(input logic [15:0] r);
    return {6'h00, r[14:11], r[10] & r[8], r[8], r[6], r[3], r[1], r[0]};
  endfunction : exp_ctrl
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [15:0] exp);
    host_u.rd(8'h00, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask : rd_chk
  task automatic pin_low();
    pin_reset_b_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk({15'h0000, sm_reset_o}, 16'h0001);
    pin_reset_b_i <= 1'b1;
  endtask : pin_low
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    {fails, cmp_count, cyc} = '0;
    seed = 42;
    rst_b_i = 1'b0;
    pin_reset_b_i = 1'b1;
    cal_done_i = 1'b0;
    nv_load_i = '0;
    cap_code_i = 8'h00;
    cross_code_i = 8'h00;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd_chk(16'h0000);
    for (i = 0; i < 30; i++) begin
      w = 16'($random(seed));
      if (i == 0) w = 16'hffff;
      if (i == 1) w = 16'h0400;
      host_u.wr(8'h00, w);
      p = {12'h000, w[5], w[4], w[2], w[2]};
      @(posedge ref_clk_i);
      chk({12'h000, pulses}, p);
      e = w & GCR_STORE_MASK;
      rd_chk(e);
      chk({12'h000, pulses}, 16'h0000);
      chk({6'h00, ctrl_o}, exp_ctrl(e));
      chk({15'h0000, nv_addr_lsb_o}, {15'h0000, w[15]});
    end
    host_u.wr(8'h01, 16'hffff);
    rd_chk(e);
    host_u.rd(8'h05, d, v);
    chk({15'h0000, v}, 16'h0000);
    for (i = 1; i >= 0; i--) begin
      @(posedge ref_clk_i);
      nv_load_i <= '{load: 1'b1, addr_lsb: i[0]};
      @(posedge ref_clk_i);
      nv_load_i <= '{load: 1'b0, addr_lsb: ~i[0]};
      rd_chk({i[0], e[14:0]});
    end
    cap_code_i <= 8'($random(seed));
    cross_code_i <= 8'($random(seed));
    cal_done_i <= 1'b1;
    host_u.wr(8'h00, 16'h0010);
    @(posedge ref_clk_i);
    chk({cal_use_held_o, 7'h00, cal_seed_cap_o}, {8'h80, cap_code_i});
    chk({8'h00, cal_seed_cross_o}, {8'h00, cross_code_i});
    host_u.wr(8'h00, 16'h5d43);
    pin_low();
    rd_chk(16'h0000);
    host_u.wr(8'h00, 16'h4108);
    pin_low();
    rd_chk(16'h4108);
    tally_and_finish();
  end
endmodule : tb_generic_control_register
